// [hw/io_route_pkg.sv]
package io_route_pkg;
	localparam int SRC_COUNT = 64;
	localparam int SEL_W = 6;
	localparam int DYN_PER_CH = 4;
	localparam int CONN_PER_CH = 3;
	localparam int BOX_OUTS = 36;
	localparam int BOX_GROUPS = 12;
	localparam int BOX_PER_GROUP = 3;
	localparam int BOX_INS = 36;
	localparam int MAX_CH = 4;
	localparam int FIELD_W = 5;
	// Global word indices
	localparam logic [5:0] G_STATIC_LO = 6'h00;
	localparam logic [5:0] G_STATIC_HI = 6'h01;
	localparam logic [5:0] G_BOXIN_LO = 6'h02;
	localparam logic [5:0] G_BOXIN_HI = 6'h03;
	localparam logic [5:0] G_BOX_GRP0 = 6'h10;
	// Per channel word indices, channel c sits in 256-byte page c+1
	localparam logic [5:0] C_PICK = 6'h00;
	localparam logic [5:0] C_FILTER = 6'h01;
	localparam logic [5:0] C_SCALE = 6'h02;
	localparam logic [5:0] C_DYN_SEL = 6'h03;
	localparam logic [5:0] C_DEST_EN = 6'h04;
	localparam logic [5:0] C_SW = 6'h05;
	localparam logic [5:0] C_GEN = 6'h06;
	localparam logic [5:0] C_RB_LO = 6'h08;
	localparam logic [5:0] C_RB_HI = 6'h09;
	localparam logic [5:0] C_STATUS = 6'h0a;
	localparam int CH_RW_REGS = 7;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// Field positions
	localparam int SCALE_MUL_BIT = 10;
	localparam int QUAD_FWD_BIT = 8;
	localparam int QUAD_REV_BIT = 9;
	localparam int GEN_TRIG_BIT = 16;
	localparam int ROUTE_CAM_BIT = 8;
	// Candidate source indices (0 means no source)
	localparam int S_NONE = 0;
	localparam int S_BOX_IN = 1;
	localparam int S_TRIG_TTL = 37;
	localparam int S_SW_TRIG = 43;
	localparam int S_MASTER_TRIG = 46;
	localparam int S_OWN_GEN = 49;
	localparam int S_MASTER_GEN = 50;
	localparam int S_QUAD = 51;
	localparam int S_SCALER = 52;
	localparam int S_CAM_TRIG = 53;
	localparam int S_OWN_PICKS = 54;
	localparam int S_USED = 57;

	typedef struct packed {
		logic cam_trig_in;
		logic encb_dif;
		logic encb_ttl;
		logic enca_dif;
		logic enca_ttl;
		logic trig_dif;
		logic trig_ttl;
	} ch_pins_t;

	typedef struct packed {
		logic chan_quad_decoder_out;
		logic chan_rate_scaler_out;
		logic chan_phase_b_pick;
		logic chan_phase_a_pick;
		logic chan_trigger_pick;
	} internal_t;
endpackage

// [hw/io_routing.sv]
`timescale 1ns/1ps
// Summary of operation
// - Trigger, phase A, phase B and scaler source each pick one of 64
// - Five internal signals in each channel
// - Channels may take master trigger independently
// - Quadrature decoder uses picked phases A, B
// - Rate scaler divides or multiplies chosen source
// - Filter swallows pulses no longer than length
// - Destinations listen only when enabled, except connector outputs, which always follow
// - Four selectable dynamic outputs per channel
// - Global page holds thirty-six static outputs
// - Dynamic outputs to camera or connector
// - Box outputs static level or dynamic
// - Twelve independent three-output box routers
// - Every input level readable by software
// - Generators selectable, triggerable by internal signal
// - Per channel selector copy, master inputs
module io_routing #(
	parameter int NUM_CH = 4
) (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic [io_route_pkg::BOX_INS-1:0] I_BOX_IN,
	input wire io_route_pkg::ch_pins_t [NUM_CH-1:0] I_CH_PINS,
	output logic [NUM_CH-1:0] O_FRAME_TRIG,
	output logic [NUM_CH-1:0] O_LINE_TRIG,
	output logic [NUM_CH*io_route_pkg::DYN_PER_CH-1:0] O_CAM_CC,
	output logic [NUM_CH*io_route_pkg::CONN_PER_CH-1:0] O_CONN_CC,
	output logic [io_route_pkg::BOX_OUTS-1:0] O_STATIC_OUT,
	output logic [io_route_pkg::BOX_OUTS-1:0] O_BOX_OUT
);
	import io_route_pkg::*;

	if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
		$error("NUM_CH must be 1 to 4");
	end

	// Register storage
	logic [31:0] ch_r [NUM_CH*8];
	logic [BOX_OUTS-1:0] static_r;
	logic [31:0] grp_r [BOX_GROUPS];

	// Bus address phase capture
	logic wr_pend_r;
	logic [3:0] wr_page_r;
	logic [5:0] wr_word_r;
	wire take = I_HSEL && I_HTRANS[1] && I_HREADY;
	wire [3:0] a_page = I_HADDR[11:8];
	wire [5:0] a_word = I_HADDR[7:2];
	wire [3:0] a_ch = a_page - 4'h1;
	wire a_is_ch = (a_page != 4'h0) && (a_page <= 4'(NUM_CH));

	// Per channel datapath results
	logic [SRC_COUNT-1:0] cand [NUM_CH];
	internal_t sig [NUM_CH];
	logic [NUM_CH-1:0] gen_out;
	logic [DYN_PER_CH-1:0] dyn [NUM_CH];
	logic [15:0] dyn_pool;

	// Read data decode
	wire [31:0] ch_rd_rw = ch_r[{a_ch[1:0], a_word[2:0]}];
	wire [31:0] ch_rb_lo = cand[a_ch[1:0]][31:0];
	wire [31:0] ch_rb_hi = cand[a_ch[1:0]][63:32];
	wire [31:0] ch_stat = {22'h0, dyn[a_ch[1:0]], gen_out[a_ch[1:0]], sig[a_ch[1:0]]};
	wire [31:0] grp_rd = grp_r[a_word[3:0]];
	wire grp_hit = (a_word >= G_BOX_GRP0) && (a_word < G_BOX_GRP0 + 6'(BOX_GROUPS));
	wire [31:0] glob_rd =
		(a_word == G_STATIC_LO) ? static_r[31:0] :
		(a_word == G_STATIC_HI) ? {28'h0, static_r[35:32]} :
		(a_word == G_BOXIN_LO) ? I_BOX_IN[31:0] :
		(a_word == G_BOXIN_HI) ? {28'h0, I_BOX_IN[35:32]} :
		grp_hit ? grp_rd : 32'h0;
	wire [31:0] chan_rd =
		(a_word < 6'(CH_RW_REGS)) ? ch_rd_rw :
		(a_word == C_RB_LO) ? ch_rb_lo :
		(a_word == C_RB_HI) ? ch_rb_hi :
		(a_word == C_STATUS) ? ch_stat : 32'h0;
	wire [31:0] rd_nxt = (!take || I_HWRITE) ? 32'h0 :
		(a_page == 4'h0) ? glob_rd : a_is_ch ? chan_rd : 32'h0;

	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			wr_pend_r <= 1'b0;
			wr_page_r <= 4'h0;
			wr_word_r <= 6'h00;
			O_HRDATA <= 32'h0;
			O_HREADYOUT <= 1'b0;
			O_HRESP <= 1'b0;
		end else begin
			wr_pend_r <= take && I_HWRITE;
			wr_page_r <= a_page;
			wr_word_r <= a_word;
			O_HRDATA <= rd_nxt;
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end
	end

	// Data phase writes; unmapped or read-only words are dropped silently
	wire [3:0] w_ch = wr_page_r - 4'h1;
	wire w_ch_ok = wr_pend_r && (wr_page_r != 4'h0) && (wr_page_r <= 4'(NUM_CH))
		&& (wr_word_r < 6'(CH_RW_REGS));
	wire w_glob = wr_pend_r && (wr_page_r == 4'h0);
	wire w_grp = w_glob && (wr_word_r >= G_BOX_GRP0)
		&& (wr_word_r < G_BOX_GRP0 + 6'(BOX_GROUPS));

	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			for (int i = 0; i < NUM_CH*8; i++) ch_r[i] <= REG_RESET;
			for (int g = 0; g < BOX_GROUPS; g++) grp_r[g] <= REG_RESET;
			static_r <= '0;
		end else begin
			if (w_ch_ok) ch_r[{w_ch[1:0], wr_word_r[2:0]}] <= I_HWDATA;
			if (w_grp) grp_r[wr_word_r[3:0]] <= I_HWDATA;
			if (w_glob && wr_word_r == G_STATIC_LO) static_r[31:0] <= I_HWDATA;
			if (w_glob && wr_word_r == G_STATIC_HI) static_r[35:32] <= I_HWDATA[3:0];
		end
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		wire [31:0] pick_r = ch_r[c*8 + 0];
		wire [31:0] filt_r = ch_r[c*8 + 1];
		wire [31:0] scale_r = ch_r[c*8 + 2];
		wire [31:0] dsel_r = ch_r[c*8 + 3];
		wire [31:0] dest_r = ch_r[c*8 + 4];
		wire [31:0] sw_r = ch_r[c*8 + 5];
		wire [31:0] genc_r = ch_r[c*8 + 6];
		// Each channel owns its candidate set; master entries come from channel 0
		assign cand[c] = {7'h0, sig[c].chan_phase_b_pick, sig[c].chan_phase_a_pick,
			sig[c].chan_trigger_pick, I_CH_PINS[c].cam_trig_in,
			sig[c].chan_rate_scaler_out, sig[c].chan_quad_decoder_out,
			gen_out[0], gen_out[c],
			sig[0].chan_phase_b_pick, sig[0].chan_phase_a_pick,
			sig[0].chan_trigger_pick,
			sw_r[2:0], I_CH_PINS[c].encb_dif, I_CH_PINS[c].encb_ttl,
			I_CH_PINS[c].enca_dif, I_CH_PINS[c].enca_ttl,
			I_CH_PINS[c].trig_dif, I_CH_PINS[c].trig_ttl, I_BOX_IN, 1'b0};

		// Trigger, phase A, phase B: pick then noise filter
		logic [2:0] filt_q;
		for (genvar f = 0; f < 3; f++) begin : g_filt
			wire raw = cand[c][pick_r[f*SEL_W +: SEL_W]];
			logic [7:0] cnt_r;
			logic out_r;
			always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
				if (I_SYS_RST) begin
					cnt_r <= 8'h00;
					out_r <= 1'b0;
				end else if (raw == out_r) begin
					cnt_r <= 8'h00;
				end else if (cnt_r >= filt_r[7:0]) begin
					out_r <= raw;
					cnt_r <= 8'h00;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
			assign filt_q[f] = out_r;
		end

		// Quadrature decoder on picked phases
		logic a_d_r;
		logic quad_r;
		wire a_rise = filt_q[1] && !a_d_r;
		wire fwd = !filt_q[2];
		// Rate scaler: divide counts rising edges, multiply doubles edge rate
		wire sc_in = cand[c][pick_r[3*SEL_W +: SEL_W]];
		logic sc_d_r;
		logic [7:0] sc_cnt_r;
		logic sc_r;
		wire sc_rise = sc_in && !sc_d_r;
		wire sc_edge = sc_in != sc_d_r;
		wire sc_wrap = sc_cnt_r >= (scale_r[7:0] - 8'h01);
		// Signal generator, free or fired by the picked trigger
		logic t_d_r;
		logic [15:0] g_cnt_r;
		logic g_r;
		wire t_rise = filt_q[0] && !t_d_r;
		wire g_end = g_cnt_r >= genc_r[15:0];
		always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
			if (I_SYS_RST) begin
				a_d_r <= 1'b0;
				quad_r <= 1'b0;
				sc_d_r <= 1'b0;
				sc_cnt_r <= 8'h00;
				sc_r <= 1'b0;
				t_d_r <= 1'b0;
				g_cnt_r <= 16'h0000;
				g_r <= 1'b0;
			end else begin
				a_d_r <= filt_q[1];
				quad_r <= a_rise && ((fwd && scale_r[QUAD_FWD_BIT]) ||
					(!fwd && scale_r[QUAD_REV_BIT]));
				sc_d_r <= sc_in;
				if (scale_r[SCALE_MUL_BIT]) begin
					sc_r <= sc_edge;
				end else if (sc_rise) begin
					sc_cnt_r <= sc_wrap ? 8'h00 : sc_cnt_r + 8'h01;
					if (sc_wrap) sc_r <= !sc_r;
				end
				t_d_r <= filt_q[0];
				if (genc_r[GEN_TRIG_BIT]) begin
					if (t_rise) begin
						g_r <= 1'b1;
						g_cnt_r <= 16'h0000;
					end else if (g_r) begin
						g_cnt_r <= g_cnt_r + 16'h0001;
						if (g_end) g_r <= 1'b0;
					end
				end else if (genc_r[15:0] == 16'h0000) begin
					g_r <= 1'b0;
					g_cnt_r <= 16'h0000;
				end else if (g_end) begin
					g_r <= !g_r;
					g_cnt_r <= 16'h0000;
				end else begin
					g_cnt_r <= g_cnt_r + 16'h0001;
				end
			end
		end
		assign gen_out[c] = g_r;
		assign sig[c] = '{chan_quad_decoder_out: quad_r, chan_rate_scaler_out: sc_r,
			chan_phase_b_pick: filt_q[2], chan_phase_a_pick: filt_q[1],
			chan_trigger_pick: filt_q[0]};

		// Dynamic outputs and hardwired destinations
		logic [DYN_PER_CH-1:0] dyn_r;
		for (genvar k = 0; k < DYN_PER_CH; k++) begin : g_dyn
			always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
				if (I_SYS_RST) begin
					dyn_r[k] <= 1'b0;
					O_CAM_CC[c*DYN_PER_CH + k] <= 1'b0;
				end else begin
					dyn_r[k] <= cand[c][dsel_r[k*SEL_W +: SEL_W]];
					O_CAM_CC[c*DYN_PER_CH + k] <= dyn_r[k] && dest_r[ROUTE_CAM_BIT + k];
				end
			end
		end
		assign dyn[c] = dyn_r;
		always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
			if (I_SYS_RST) begin
				O_CONN_CC[c*CONN_PER_CH +: CONN_PER_CH] <= '0;
				O_FRAME_TRIG[c] <= 1'b0;
				O_LINE_TRIG[c] <= 1'b0;
			end else begin
				O_CONN_CC[c*CONN_PER_CH +: CONN_PER_CH] <= dyn_r[3:1];
				O_FRAME_TRIG[c] <= filt_q[0] && dest_r[0];
				O_LINE_TRIG[c] <= (filt_q[1] && dest_r[1]) || (quad_r && dest_r[2]) ||
					(sc_r && dest_r[3]);
			end
		end
	end

	// Pool of all dynamic outputs for the box routers
	for (genvar p = 0; p < 16; p++) begin : g_pool
		if (p < NUM_CH*DYN_PER_CH) begin : g_on
			assign dyn_pool[p] = dyn[p/DYN_PER_CH][p%DYN_PER_CH];
		end else begin : g_off
			assign dyn_pool[p] = 1'b0;
		end
	end

	// Box routers: group g drives output g of each of the three banks
	for (genvar g = 0; g < BOX_GROUPS; g++) begin : g_box
		for (genvar j = 0; j < BOX_PER_GROUP; j++) begin : g_slot
			localparam int IDX = j*BOX_GROUPS + g;
			wire [FIELD_W-1:0] fld = grp_r[g][j*FIELD_W +: FIELD_W];
			always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
				if (I_SYS_RST) begin
					O_BOX_OUT[IDX] <= 1'b0;
				end else begin
					O_BOX_OUT[IDX] <= fld[4] ? dyn_pool[fld[3:0]] : static_r[IDX];
				end
			end
		end
	end

	assign O_STATIC_OUT = static_r;
endmodule

// [test/io_routing_checker.sv]
`timescale 1ns/1ps
module io_routing_checker #(
	parameter int NUM_CH = 4
) (
	input wire logic I_MCLK,
	input wire logic I_SYS_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	input wire logic [31:0] O_HRDATA,
	input wire logic O_HREADYOUT,
	input wire logic O_HRESP,
	input wire logic [35:0] I_BOX_IN,
	input wire logic [35:0] O_STATIC_OUT,
	input wire logic [35:0] O_BOX_OUT,
	input wire logic [NUM_CH-1:0] O_FRAME_TRIG
);
	logic take, wr_q, rd_q, den0;
	logic [11:0] addr_q;
	assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
	// Mirror of channel 0 destination enable, tracked from bus writes
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			addr_q <= 12'h0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			den0 <= 1'b0;
		end else begin
			addr_q <= I_HADDR[11:0];
			wr_q <= take & I_HWRITE;
			rd_q <= take & ~I_HWRITE;
			if (wr_q && addr_q == 12'h110) begin
				den0 <= I_HWDATA[0];
			end
		end
	end
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (I_SYS_RST);
	property p_ready;
		!$past(I_SYS_RST) |-> O_HREADYOUT;
	endproperty
	a_ready: assert property (p_ready) else $error("hreadyout low");
	property p_okay;
		O_HRESP == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_static;
		wr_q && addr_q == 12'h000 |=> O_STATIC_OUT[31:0] == $past(I_HWDATA);
	endproperty
	a_static: assert property (p_static) else $error("static level wrong");
	// Read data is captured at the address edge, so compare with the levels seen there
	property p_rb_box;
		take && !I_HWRITE && I_HADDR[11:0] == 12'h008
			|=> O_HRDATA == $past(I_BOX_IN[31:0]);
	endproperty
	a_rb_box: assert property (p_rb_box) else $error("box input readback wrong");
	property p_unmapped;
		take && !I_HWRITE && I_HADDR[11:0] == 12'h03c |=> O_HRDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_rdata_idle;
		!rd_q |-> O_HRDATA == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside phase");
	property p_reset_out;
		$fell(I_SYS_RST) |-> O_STATIC_OUT == 36'h0 && O_BOX_OUT == 36'h0 && O_FRAME_TRIG == '0;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs set at reset");
	property p_gate;
		!den0 && !$past(den0) && !$past(den0, 2) |-> !O_FRAME_TRIG[0];
	endproperty
	a_gate: assert property (p_gate) else $error("frame trigger while disabled");
	c_frame: cover property (O_FRAME_TRIG[0]);
	c_box: cover property (O_BOX_OUT[0]);
	c_read: cover property (rd_q && O_HRDATA != 32'h0);
endmodule

// [test/io_box_model.sv]
`timescale 1ns/1ps
module io_box_model (
	input wire logic i_clk,
	input wire logic [35:0] i_levels,
	output logic [35:0] o_box_in
);
	// Levels move only on edges, like the box receivers behind the cable
	initial o_box_in = 36'h0;
	always @(posedge i_clk) begin
		o_box_in <= i_levels;
	end
endmodule

// [test/tb_io_routing.sv]
`timescale 1ns/1ps
module tb_io_routing;
	import io_route_pkg::*;
	logic I_MCLK, I_SYS_RST, I_HSEL, I_HWRITE, O_HREADYOUT, O_HRESP;
	logic [1:0] I_HTRANS;
	logic [2:0] I_HSIZE;
	logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rd;
	logic [35:0] box_lvl, I_BOX_IN, O_STATIC_OUT, O_BOX_OUT;
	logic [3:0] O_FRAME_TRIG, O_LINE_TRIG;
	logic [15:0] O_CAM_CC;
	logic [11:0] O_CONN_CC;
	ch_pins_t [3:0] I_CH_PINS;
	wire logic I_HREADY = O_HREADYOUT;
	int errors = 0;
	int comparisons = 0;
	io_routing #(.NUM_CH(4)) io_routing_inst (.I_MCLK, .I_SYS_RST, .I_HSEL, .I_HADDR, .I_HTRANS,
		.I_HWRITE, .I_HSIZE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .I_BOX_IN,
		.I_CH_PINS, .O_FRAME_TRIG, .O_LINE_TRIG, .O_CAM_CC, .O_CONN_CC, .O_STATIC_OUT, .O_BOX_OUT);
	io_box_model io_box_model_inst (.i_clk(I_MCLK), .i_levels(box_lvl), .o_box_in(I_BOX_IN));
	task automatic stop_test;
		$display("Comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge I_MCLK);
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		I_HTRANS <= 2'b10;
		I_HADDR <= a;
		I_HWRITE <= w;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (I_HREADY !== 1'b1 && n < 64);
		I_HTRANS <= 2'b00;
		I_HWDATA <= d;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (I_HREADY !== 1'b1 && n < 64);
		rd = O_HRDATA;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic pulse(input int n, input logic exp);
		logic hit;
		hit = 1'b0;
		I_CH_PINS[0].trig_ttl <= 1'b1;
		for (int i = 0; i < n + 12; i++) begin
			@(posedge I_MCLK);
			hit = hit | O_FRAME_TRIG[0];
			if (i == n - 1) begin
				I_CH_PINS[0].trig_ttl <= 1'b0;
			end
		end
		check(hit, exp);
	endtask
	initial begin
		I_MCLK = 1'b0;
		forever #2.5 I_MCLK = ~I_MCLK;
	end
	initial begin
		tick(5000);
		errors++;
		stop_test();
	end
	initial begin
		I_SYS_RST = 1'b1;
		I_HSEL = 1'b1;
		I_HTRANS = 2'b00;
		I_HADDR = 32'h0;
		I_HWRITE = 1'b0;
		I_HSIZE = 3'b010;
		I_HWDATA = 32'h0;
		I_CH_PINS = '0;
		box_lvl = 36'h0;
		tick(16);
		I_SYS_RST <= 1'b0;
		tick(2);
		check(O_STATIC_OUT, 36'h0);
		rdchk(32'h100, 32'h0);
		$display("Reset test done");
		wr(32'h0, 32'ha5a5_5a5a);
		wr(32'h4, 32'h9);
		tick(1);
		check(O_STATIC_OUT, 36'h9_a5a5_5a5a);
		rdchk(32'h4, 32'h9);
		box_lvl <= 36'h5_1234_abcd;
		tick(4);
		wr(32'h8, 32'h0);
		rdchk(32'h8, 32'h1234_abcd);
		rdchk(32'hc, 32'h5);
		rdchk(32'h3c, 32'h0);
		$display("Register test done");
		wr(32'h100, 32'd37);
		wr(32'h110, 32'h1);
		wr(32'h200, 32'd46);
		wr(32'h210, 32'h1);
		I_CH_PINS[0].trig_ttl <= 1'b1;
		tick(8);
		check(O_FRAME_TRIG[1:0], 2'b11);
		wr(32'h110, 32'h0);
		tick(8);
		check(O_FRAME_TRIG[1:0], 2'b10);
		I_CH_PINS[0].trig_ttl <= 1'b0;
		tick(8);
		check(O_FRAME_TRIG[1:0], 2'b00);
		wr(32'h110, 32'h1);
		wr(32'h310, 32'h1);
		for (int k = 1; k <= 36; k++) begin
			box_lvl <= 36'h1 << (k - 1);
			wr(32'h300, 32'(k));
			tick(8);
			check(O_FRAME_TRIG[2], 1'b1);
		end
		box_lvl <= '1;
		wr(32'h300, 32'd57);
		tick(8);
		check(O_FRAME_TRIG[2], 1'b0);
		// Channel 3 phase A from its software bit, line trigger enabled or not
		wr(32'h400, 32'h0000_0b00);
		wr(32'h414, 32'h2);
		tick(8);
		check(O_LINE_TRIG[3], 1'b0);
		wr(32'h410, 32'h2);
		tick(8);
		check(O_LINE_TRIG[3], 1'b1);
		$display("Pick test done");
		// Length 4: three samples too short, eight plenty
		wr(32'h104, 32'h4);
		pulse(3, 1'b0);
		pulse(8, 1'b1);
		$display("Filter test done");
		wr(32'h114, 32'h1);
		wr(32'h10c, 32'h00ae_baeb);
		wr(32'h110, 32'h501);
		wr(32'h40, 32'h4c10);
		tick(8);
		check(O_CAM_CC[3:0], 4'h5);
		check(O_CONN_CC[2:0], 3'h7);
		check(O_BOX_OUT, 36'h9_a5a5_5a5b);
		wr(32'h114, 32'h0);
		tick(8);
		check(O_BOX_OUT, 36'h9_a4a5_5a5a);
		check(O_CAM_CC[3:0], 4'h0);
		$display("Output test done");
		stop_test();
	end
endmodule
bind io_routing io_routing_checker #(.NUM_CH(NUM_CH)) io_routing_checker_inst (.I_MCLK, .I_SYS_RST,
	.I_HSEL, .I_HADDR, .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .O_HRDATA, .O_HREADYOUT,
	.O_HRESP, .I_BOX_IN, .O_STATIC_OUT, .O_BOX_OUT, .O_FRAME_TRIG);
